// ==== hdl/spfc_pkg.sv ====
// constants and carrier types of the self-programming flash control block
`default_nettype none

package spfc_pkg;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h00;

  localparam int B_IE = 7;
  localparam int B_BUSY = 6;
  localparam int B_RES = 5;
  localparam int B_REEN = 4;
  localparam int B_LOCK = 3;
  localparam int B_WRT = 2;
  localparam int B_ERS = 1;
  localparam int B_EN = 0;

  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_WRT = 5'h05;
  localparam logic [4:0] CMD_ERS = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;

  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN = 3'h3;

  localparam logic [15:0] APP_RESET_VEC = 16'h0000;
  localparam int LOCK_LSB = 2;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_ARMED = 3'h2,
    S_OP = 3'h4
  } spfc_state_t;

  // core side: instruction strobes, pointer and data registers
  typedef struct packed {
    logic store;
    logic load;
    logic [15:0] ptr;
    logic [7:0] lo;
    logic [7:0] hi;
    logic gie;
    logic ee_busy;
  } spfc_core_t;

  // flash array side: start pulses and latched target
  typedef struct packed {
    logic erase;
    logic write;
    logic lock_prog;
    logic [3:0] lock_mask;
    logic [15:0] page;
  } spfc_arr_t;

endpackage : spfc_pkg

`default_nettype wire

// ==== hdl/spfc_page_buf.sv ====
// temporary page buffer held in flip-flops
`default_nettype none

module spfc_page_buf #(
  parameter int WORD_W = 5,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic clr,
  input wire logic wr,
  input wire logic [WORD_W-1:0] widx,
  input wire logic [DATA_W-1:0] wdata,
  // drain side, one cycle latency
  input wire logic [WORD_W-1:0] ridx,
  output logic [DATA_W-1:0] rdata
);

  localparam int DEPTH = 2 ** WORD_W;

  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [DATA_W-1:0] mem_nxt [DEPTH];
  logic [DATA_W-1:0] rdata_r;

  // any word may be written in any order
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_comb
    begin
      mem_nxt[i] = mem_r[i];
      if (clr)
        mem_nxt[i] = '1;
      else if (wr && widx == WORD_W'(i))
        mem_nxt[i] = wdata;
    end
  end

  // erased state is all ones, also after reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int j = 0; j < DEPTH; j++)
        mem_r[j] <= '1;
      rdata_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      rdata_r <= mem_r[ridx];
    end
  end

  assign rdata = rdata_r;

endmodule // spfc_page_buf

`default_nettype wire

// ==== hdl/spfc_top.sv ====
// self-programming control register and store/load sequencer
`default_nettype none

module spfc_top #(
  parameter int WORD_W = 5,
  parameter int PAGE_W = 7,
  parameter int HALT_FIRST_PAGE = 96,
  parameter logic [15:0] BOOT_RESET_VEC = 16'h0C00
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // processor core
  input wire spfc_pkg::spfc_core_t core,
  output logic lpm_valid,
  output logic [7:0] lpm_data,
  output logic cpu_halt,
  output logic ready_irq,
  output logic region_block,
  output logic [15:0] reset_vector,
  // fuses and lock bits, read only
  input wire logic boot_reset_select,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [5:0] lock_bits,
  // flash array
  output var spfc_pkg::spfc_arr_t arr,
  input wire logic arr_done,
  input wire logic [WORD_W-1:0] arr_word,
  output logic [15:0] buf_word
);
  import spfc_pkg::*;

  spfc_state_t st_r, st_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic halt_r, halt_nxt;
  logic irq_r, irq_nxt;
  logic lpm_v_r, lpm_v_nxt;
  logic [7:0] lpm_d_r, lpm_d_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] vec_r, vec_nxt;
  spfc_arr_t arr_r, arr_nxt;
  logic buf_clr, buf_wr, arm, wr_ctrl, cmd_take;
  logic [PAGE_W-1:0] pg;

  function automatic logic cmd_ok(input logic [4:0] c);
    return c == CMD_REEN || c == CMD_LOCK || c == CMD_WRT || c == CMD_ERS || c == CMD_LOAD;
  endfunction

  // page in the halting region stops the core while it is programmed
  function automatic logic in_halt(input logic [PAGE_W-1:0] p);
    return int'(p) >= HALT_FIRST_PAGE;
  endfunction

  assign wr_ctrl = reg_wr && reg_addr == CTRL_ADDR;
  // a data-memory write in flight locks out new commands
  assign cmd_take = wr_ctrl && !core.ee_busy && cmd_ok(reg_wdata[4:0]);
  // high pointer bits select the page, low bits the word
  assign pg = core.ptr[WORD_W+PAGE_W:WORD_W+1];

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    halt_nxt = halt_r;
    arr_nxt = arr_r;
    arr_nxt.erase = 1'b0;
    arr_nxt.write = 1'b0;
    arr_nxt.lock_prog = 1'b0;
    lpm_v_nxt = 1'b0;
    lpm_d_nxt = lpm_d_r;
    buf_clr = 1'b0;
    buf_wr = 1'b0;
    arm = 1'b0;
    if (wr_ctrl)
      ctrl_nxt[B_IE] = reg_wdata[B_IE];
    unique case (st_r)
      S_IDLE:
        arm = cmd_take;
      S_ARMED:
      begin
        if (core.store)
        begin
          unique case (ctrl_r[4:0])
            CMD_LOAD:
            begin
              buf_wr = 1'b1;
              ctrl_nxt[B_BUSY] = 1'b0;
            end
            CMD_REEN:
              ctrl_nxt[B_BUSY] = 1'b0;
            CMD_LOCK:
            begin
              // pointer and high data play no part here
              arr_nxt.lock_prog = 1'b1;
              arr_nxt.lock_mask = ~core.lo[LOCK_LSB+:4];
            end
            CMD_ERS, CMD_WRT:
            begin
              arr_nxt.erase = ctrl_r[B_ERS];
              arr_nxt.write = ctrl_r[B_WRT];
              arr_nxt.page = 16'(pg);
              halt_nxt = in_halt(pg);
              if (!in_halt(pg))
                ctrl_nxt[B_BUSY] = 1'b1;
              st_nxt = S_OP;
            end
            default:
              ;
          endcase
          // store enable stays up only for erase and write
          if (st_nxt != S_OP)
          begin
            ctrl_nxt[4:0] = '0;
            st_nxt = S_IDLE;
          end
        end
        else if (core.load && ctrl_r[B_LOCK] && !core.ee_busy && cnt_r > STORE_WIN - LOAD_WIN)
        begin
          // pointer bits 0 and 1 pick the byte; fuses are only ever read
          lpm_v_nxt = 1'b1;
          lpm_d_nxt = !core.ptr[0] ? fuse_low : core.ptr[1] ? fuse_high : {LOCK_PAD, lock_bits};
          ctrl_nxt[4:0] = '0;
          st_nxt = S_IDLE;
        end
        else if (cmd_take)
          arm = 1'b1;
        else if (cnt_r == 3'h1)
        begin
          // no store in the window: command bits drop
          ctrl_nxt[4:0] = '0;
          st_nxt = S_IDLE;
        end
        else
          cnt_nxt = cnt_r - 3'h1;
      end
      S_OP:
      begin
        // control writes other than the interrupt enable bit are ignored here
        if (arr_done)
        begin
          ctrl_nxt[4:0] = '0;
          halt_nxt = 1'b0;
          st_nxt = S_IDLE;
          buf_clr = ctrl_r[B_WRT];
        end
      end
      default:
      begin
        ctrl_nxt[4:0] = '0;
        st_nxt = S_IDLE;
      end
    endcase
    if (arm)
    begin
      ctrl_nxt[4:0] = reg_wdata[4:0];
      cnt_nxt = STORE_WIN;
      st_nxt = S_ARMED;
      // re-enable throws away a half-filled buffer
      buf_clr = reg_wdata[B_REEN];
    end
    ctrl_nxt[B_RES] = 1'b0;
  end

  always_comb
  begin
    irq_nxt = ctrl_r[B_IE] && core.gie && !ctrl_r[B_EN];
    vec_nxt = boot_reset_select ? APP_RESET_VEC : BOOT_RESET_VEC;
    rdata_nxt = 8'h00;
    if (reg_rd && reg_addr == CTRL_ADDR)
      rdata_nxt = ctrl_r;
    else if (reg_rd && reg_addr == STAT_ADDR)
      rdata_nxt = {1'b0, halt_r, st_r, cnt_r};
  end

  // vector follows the fuse only from the first edge after reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= S_IDLE;
      ctrl_r <= CTRL_RST;
      cnt_r <= 3'h0;
      halt_r <= 1'b0;
      irq_r <= 1'b0;
      lpm_v_r <= 1'b0;
      lpm_d_r <= 8'h00;
      rdata_r <= 8'h00;
      vec_r <= APP_RESET_VEC;
      arr_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      halt_r <= halt_nxt;
      irq_r <= irq_nxt;
      lpm_v_r <= lpm_v_nxt;
      lpm_d_r <= lpm_d_nxt;
      rdata_r <= rdata_nxt;
      vec_r <= vec_nxt;
      arr_r <= arr_nxt;
    end
  end

  spfc_page_buf #(
    .WORD_W(WORD_W),
    .DATA_W(16)
  ) u_buf (
    .mclk(mclk),
    .rst(rst),
    .clr(buf_clr),
    .wr(buf_wr),
    .widx(core.ptr[WORD_W:1]),
    .wdata({core.hi, core.lo}),
    .ridx(arr_word),
    .rdata(buf_word)
  );

  assign reg_rdata = rdata_r;
  assign lpm_valid = lpm_v_r;
  assign lpm_data = lpm_d_r;
  assign cpu_halt = halt_r;
  assign ready_irq = irq_r;
  // region stays blocked until busy is cleared by software
  assign region_block = ctrl_r[B_BUSY];
  assign reset_vector = vec_r;
  assign arr = arr_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence armed_s;
    st_r == S_ARMED && cnt_r == STORE_WIN;
  endsequence

  sequence op_start_s;
    st_r == S_ARMED && core.store && (ctrl_r[4:0] == CMD_ERS || ctrl_r[4:0] == CMD_WRT);
  endsequence

  reserved_zero_a: assert property (reg_rd && reg_addr == CTRL_ADDR |=> !reg_rdata[B_RES])
    else $error("reserved control bit read as one");

  window_timeout_a: assert property (armed_s ##0 (!core.store && !core.load && !reg_wr) [*4]
    |=> st_r == S_IDLE && ctrl_r[4:0] == 5'h00)
    else $error("store window did not close after four cycles");

  ready_irq_a: assert property (ctrl_r[B_IE] && core.gie && !ctrl_r[B_EN] |=> ready_irq)
    else $error("ready request missing while store enable clear");

  busy_set_a: assert property (op_start_s ##0 !in_halt(pg) |=> region_block && !cpu_halt)
    else $error("concurrent region not marked busy");

  core_halt_a: assert property (op_start_s ##0 in_halt(pg) |=> cpu_halt throughout (st_r == S_OP))
    else $error("core not halted for halting-region operation");

  load_clears_busy_a: assert property (st_r == S_ARMED && core.store && ctrl_r[4:0] == CMD_LOAD
    |=> !region_block && st_r == S_IDLE)
    else $error("buffer load left busy or enable set");

  enable_held_a: assert property (st_r == S_OP && !arr_done |=> ctrl_r[B_EN] && st_r == S_OP)
    else $error("store enable dropped during operation");

  done_clears_a: assert property (st_r == S_OP && arr_done
    |=> ctrl_r[4:0] == 5'h00 && !cpu_halt && st_r == S_IDLE)
    else $error("completion did not clear command bits together");

  page_latch_a: assert property (op_start_s |=> (arr.page == $past(16'(pg))) [*2])
    else $error("latched page moved during operation");

  cmd_filter_a: assert property (st_r == S_IDLE && wr_ctrl && !cmd_ok(reg_wdata[4:0])
    |=> st_r == S_IDLE && ctrl_r[4:0] == 5'h00)
    else $error("unlisted command pattern took effect");

  ee_block_a: assert property (st_r == S_IDLE && core.ee_busy |=> st_r == S_IDLE)
    else $error("command accepted during data-memory write");

endmodule // spfc_top

`default_nettype wire

// ==== sim/spfc_core_model.sv ====
// core and flash array model facing the self-programming block
`default_nettype none

module spfc_core_model #(
  parameter int DONE_DLY = 8
) (
  // clock
  input wire logic mclk,
  // core side
  input wire logic gie,
  input wire logic ee_busy,
  output var spfc_pkg::spfc_core_t core,
  input wire logic lpm_valid,
  input wire logic [7:0] lpm_data,
  // flash array side
  input wire spfc_pkg::spfc_arr_t arr,
  output logic arr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import spfc_pkg::*;
  logic store = 1'b0;
  logic load = 1'b0;
  logic [15:0] ptr = 16'h0000;
  logic [7:0] lo = 8'h00;
  logic [7:0] hi = 8'h00;
  logic [3:0] last_mask = 4'h0;
  logic [1:0] last_op = 2'h0;
  logic [7:0] last_lpm = 8'h00;
  int busy_cnt = 0;

  always_comb core = {store, load, ptr, lo, hi, gie, ee_busy};
  initial arr_done = 1'b0;

  task automatic store_op(input logic [15:0] p, input logic [7:0] l, input logic [7:0] h);
    @(posedge mclk);
    store <= 1'b1;
    ptr <= p;
    lo <= l;
    hi <= h;
    @(posedge mclk);
    store <= 1'b0;
  endtask

  task automatic load_op(input logic [15:0] p);
    @(posedge mclk);
    load <= 1'b1;
    ptr <= p;
    @(posedge mclk);
    load <= 1'b0;
  endtask

  // array busy a fixed time, then one completion pulse
  always @(posedge mclk)
  begin
    arr_done <= 1'b0;
    if (arr.erase || arr.write)
    begin
      busy_cnt <= DONE_DLY;
      last_op <= {arr.write, arr.erase};
    end
    else if (busy_cnt > 0)
    begin
      busy_cnt <= busy_cnt - 1;
      arr_done <= (busy_cnt == 1);
    end
    if (arr.lock_prog)
      last_mask <= arr.lock_mask;
    if (lpm_valid)
      last_lpm <= lpm_data;
  end
endmodule // spfc_core_model

`default_nettype wire

// ==== sim/self_program_flash_control_bench.sv ====
// self-checking bench of the self-programming flash control block
`default_nettype none

module self_program_flash_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spfc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic gie = 1'b0;
  logic ee_busy = 1'b0;
  logic boot_reset_select = 1'b1;
  logic [4:0] arr_word = 5'h03;
  logic lpm_valid, cpu_halt, ready_irq, region_block, arr_done;
  logic [7:0] lpm_data;
  logic [15:0] reset_vector, buf_word;
  spfc_core_t core;
  spfc_arr_t arr;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] pages [2] = '{16'd100, 16'd10};
  logic [15:0] lptr [3] = '{16'h0000, 16'h0003, 16'h0001};
  logic [7:0] lexp [3] = '{8'h3C, 8'hC5, 8'hEA};

  initial forever #50 mclk = ~mclk;

  spfc_top dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core(core), .lpm_valid(lpm_valid), .lpm_data(lpm_data),
    .cpu_halt(cpu_halt), .ready_irq(ready_irq), .region_block(region_block), .reset_vector(reset_vector),
    .boot_reset_select(boot_reset_select), .fuse_low(8'h3C), .fuse_high(8'hC5), .lock_bits(6'h2A),
    .arr(arr), .arr_done(arr_done), .arr_word(arr_word), .buf_word(buf_word));
  spfc_core_model core_u (.mclk(mclk), .gie(gie), .ee_busy(ee_busy), .core(core), .lpm_valid(lpm_valid),
    .lpm_data(lpm_data), .arr(arr), .arr_done(arr_done));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    check(reg_rdata, exp);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(CTRL_ADDR, 8'h00);
    check(reset_vector, 16'h0000);
    $display("test reset done");
    wr(CTRL_ADDR, 8'h07);
    rd_chk(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'hFF);
    rd_chk(CTRL_ADDR, 8'h80);
    gie <= 1'b1;
    repeat (2) @(posedge mclk);
    check(ready_irq, 16'h1);
    wr(CTRL_ADDR, 8'h81);
    repeat (2) @(posedge mclk);
    check(ready_irq, 16'h0);
    repeat (6) @(posedge mclk);
    rd_chk(CTRL_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'h00);
    gie <= 1'b0;
    $display("test patterns done");
    // erase then write the same page, halting page first
    foreach (pages[i])
    begin
      wr(CTRL_ADDR, 8'h01);
      core_u.store_op(16'h0007, pages[i][7:0], 8'hA5);
      rd_chk(CTRL_ADDR, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
        wr(CTRL_ADDR, (k == 1) ? 8'h05 : 8'h03);
        core_u.store_op(pages[i] << 6, 8'h00, 8'h00);
        repeat (2) @(posedge mclk);
        check(cpu_halt, pages[i] >= 96);
        check(region_block, pages[i] < 96);
        check(arr.page, pages[i]);
        check(core_u.last_op, (k == 1) ? 16'h2 : 16'h1);
        core_u.load_op(16'h0000);
        check(arr.page, pages[i]);
        rd_chk(CTRL_ADDR, {1'b0, pages[i] < 96, 3'h0, (k == 1) ? 3'h5 : 3'h3});
        check(buf_word, {8'hA5, pages[i][7:0]});
        repeat (12) @(posedge mclk);
        rd_chk(CTRL_ADDR, {1'b0, pages[i] < 96, 6'h00});
        check(cpu_halt, 16'h0);
      end
      check(buf_word, 16'hFFFF);
    end
    wr(CTRL_ADDR, 8'h11);
    core_u.store_op(16'h0000, 8'h00, 8'h00);
    repeat (2) @(posedge mclk);
    check(region_block, 16'h0);
    // words loaded out of order, each read back by index
    wr(CTRL_ADDR, 8'h01);
    core_u.store_op(16'h0006, 8'h78, 8'h56);
    wr(CTRL_ADDR, 8'h01);
    core_u.store_op(16'h0002, 8'h34, 8'h12);
    repeat (2) @(posedge mclk);
    check(buf_word, 16'h5678);
    arr_word <= 5'h01;
    repeat (2) @(posedge mclk);
    check(buf_word, 16'h1234);
    arr_word <= 5'h03;
    wr(CTRL_ADDR, 8'h11);
    repeat (2) @(posedge mclk);
    check(buf_word, 16'hFFFF);
    $display("test erase and write done");
    wr(CTRL_ADDR, 8'h09);
    core_u.store_op(16'h0001, 8'hD7, 8'h00);
    repeat (2) @(posedge mclk);
    check(core_u.last_mask, 16'hA);
    rd_chk(CTRL_ADDR, 8'h00);
    foreach (lptr[i])
    begin
      wr(CTRL_ADDR, 8'h09);
      core_u.load_op(lptr[i]);
      repeat (2) @(posedge mclk);
      check(core_u.last_lpm, lexp[i]);
    end
    $display("test lock bits done");
    ee_busy <= 1'b1;
    wr(CTRL_ADDR, 8'h01);
    rd_chk(CTRL_ADDR, 8'h00);
    ee_busy <= 1'b0;
    boot_reset_select <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check(reset_vector, 16'h0C00);
    $display("test busy and vector done");
    tally_and_finish();
  end
endmodule // self_program_flash_control_bench

`default_nettype wire
